/* core/sscr_top.sv */
// serial programming, holding registers and coarse tuning search of the synthesizer
//
// Overview of operation
// - search yields a seven bit coarse code for the oscillator capacitors
// - seven step successive approximation, analog tuning switched in only afterwards
// - a run starts after power on reset and after a rise of the loop enable bit
// - word with address 00 loads the operation mode register
// - address 01 loads calibration, 10 frequency one, 11 frequency two
// - pump current code selects 200 to 1600 microamps in eight steps of 200
// - pump delay field is ignored, the 2 ns delay always applies
// - detector polarity field is ignored, negative polarity always applies
// - pump disable bit set turns the charge pump output off
// - reference buffer bandwidth codes select 20, 30, 40, 50 MHz
// - diagnostic select routes lock, reference, N divider or loop test out
// - prescaler bias codes select 20, 22, 24 or 26 microamps
// - ratio bit picks 8/9 when zero, 16/17 when one
// - loop enable bit drives the digital loop, its rise arms tuning
// - each transfer is a 26 bit word sent msb first
// - one data bit shifts in per serial clock rise while strobe low
// - strobe falling edge copies the load register to the addressed register
// - calibration bits 19 to 2 drive the loop control ports directly
`timescale 1ns/1ns
`default_nettype none
module sscr_top
  import sscr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        latch_strobe,
  input  wire logic        vco_freq_high,
  input  wire logic        lock_detect_in,
  input  wire logic        ref_div_in,
  input  wire logic        n_div_in,
  input  wire logic        loop_test_in,
  output logic [2:0]       pump_current_select,
  output logic [10:0]      pump_current_ua,
  output logic [1:0]       pump_delay_select,
  output logic             detector_polarity,
  output logic             pump_output_disable,
  output logic             modulator_supply_ctrl,
  output logic             divider_supply_ctrl,
  output logic             pll_supply_ctrl,
  output logic [1:0]       reference_buffer_bandwidth,
  output logic [5:0]       ref_bw_mhz,
  output logic             diag_out,
  output logic [4:0]       prescaler_bias_ua,
  output logic             prescaler_ratio_sel,
  output logic [17:0]      loop_ctrl,
  output logic             loop_enable,
  output logic [23:0]      freq_ctrl_one,
  output logic [23:0]      freq_ctrl_two,
  output logic [6:0]       coarse_code,
  output logic             tune_busy,
  output logic             analog_tune_en
);

  logic        nrst_m;
  logic        nrst_q;
  logic [2:0]  pin_m;
  logic [2:0]  pin_s;
  logic [2:0]  pin_d;
  logic        clk_rise;
  logic        strobe_fall;
  logic [25:0] load_word;
  logic [23:0] operation_mode;
  logic [23:0] auto_calibration_control;
  logic [23:0] frequency_control_one;
  logic [23:0] frequency_control_two;
  logic        loop_en_prev;
  logic        loop_en_rise;
  logic        start_req;
  sscr_tune_t  tune_state;
  logic [2:0]  tune_idx;
  logic [9:0]  tune_cnt;
  logic        step_end;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst_q || !ce);

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nrst_m <= 1'b0;
      nrst_q <= 1'b0;
    end else begin
      nrst_m <= 1'b1;
      nrst_q <= nrst_m;
    end
  end

  // pin synchronisers: bit 2 clock, bit 1 data, bit 0 strobe
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      pin_m <= 3'h7;
      pin_s <= 3'h7;
      pin_d <= 3'h7;
    end else if (ce) begin
      pin_m <= {ser_clk, ser_data, latch_strobe};
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  assign clk_rise    = pin_s[2] & ~pin_d[2];
  assign strobe_fall = ~pin_s[0] & pin_d[0];

  // load register, msb first
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      load_word <= LOAD_RESET;
    end else if (ce && clk_rise && !pin_s[0]) begin
      load_word <= {load_word[WORD_BITS-2:0], pin_s[1]};
    end
  end

  chk_shift_in: assert property (
    clk_rise && !pin_s[0] |=> load_word[0] == $past(pin_s[1])
                           && load_word[25:1] == $past(load_word[24:0])
  ) else $error("serial bit not shifted into load register");

  // holding registers, chosen by the two address bits
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      operation_mode           <= HOLD_RESET;
      auto_calibration_control <= HOLD_RESET;
      frequency_control_one    <= HOLD_RESET;
      frequency_control_two    <= HOLD_RESET;
    end else if (ce && strobe_fall) begin
      case (load_word[1:0])
        ADDR_OPMODE:   operation_mode           <= load_word[HOLD_BITS-1:0];
        ADDR_AUTOCAL:  auto_calibration_control <= load_word[HOLD_BITS-1:0];
        ADDR_FREQ_ONE: frequency_control_one    <= load_word[HOLD_BITS-1:0];
        ADDR_FREQ_TWO: frequency_control_two    <= load_word[HOLD_BITS-1:0];
        default:       operation_mode           <= operation_mode;
      endcase
    end
  end

  chk_latch_opmode: assert property (
    strobe_fall && load_word[1:0] == ADDR_OPMODE |=> operation_mode == $past(load_word[23:0])
  ) else $error("operation mode word not latched");
  chk_latch_autocal: assert property (
    strobe_fall && load_word[1:0] == ADDR_AUTOCAL
      |=> auto_calibration_control == $past(load_word[23:0]) && $stable(operation_mode)
  ) else $error("calibration word not latched");
  chk_latch_freq: assert property (
    strobe_fall && load_word[1:0] == ADDR_FREQ_TWO
      |=> frequency_control_two == $past(load_word[23:0]) && $stable(frequency_control_one)
  ) else $error("frequency word not latched");

  // applied analog settings from the operation mode register
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      pump_current_select        <= 3'h0;
      pump_current_ua            <= PUMP_STEP_UA;
      pump_delay_select          <= PUMP_DLY_FIXED;
      detector_polarity          <= POLARITY_FIXED;
      pump_output_disable        <= 1'b0;
      modulator_supply_ctrl      <= 1'b0;
      divider_supply_ctrl        <= 1'b0;
      pll_supply_ctrl            <= 1'b0;
      reference_buffer_bandwidth <= 2'h0;
      ref_bw_mhz                 <= REF_BW_BASE;
      prescaler_bias_ua          <= PRE_BIAS_BASE;
      prescaler_ratio_sel        <= 1'b0;
    end else if (ce) begin
      pump_current_select <= operation_mode[PUMP_CUR_MSB:PUMP_CUR_LSB];
      pump_current_ua     <= 11'(PUMP_STEP_UA
                             * ({8'h00, operation_mode[PUMP_CUR_MSB:PUMP_CUR_LSB]} + 11'h001));
      pump_delay_select   <= PUMP_DLY_FIXED;
      detector_polarity   <= POLARITY_FIXED;
      pump_output_disable <= operation_mode[PUMP_OFF_BIT];
      modulator_supply_ctrl <= operation_mode[MOD_SUPPLY_BIT];
      divider_supply_ctrl   <= operation_mode[DIV_SUPPLY_BIT];
      pll_supply_ctrl       <= operation_mode[PLL_SUPPLY_BIT];
      reference_buffer_bandwidth <= operation_mode[REF_BW_MSB:REF_BW_LSB];
      ref_bw_mhz <= 6'(REF_BW_BASE
                    + REF_BW_STEP * {4'h0, operation_mode[REF_BW_MSB:REF_BW_LSB]});
      prescaler_bias_ua <= 5'(PRE_BIAS_BASE
                    + PRE_BIAS_STEP * {3'h0, operation_mode[PRE_BIAS_MSB:PRE_BIAS_LSB]});
      prescaler_ratio_sel <= operation_mode[PRE_RATIO_BIT];
    end
  end

  chk_pump_current: assert property (
    ce ##1 ce |-> pump_current_ua == 11'(PUMP_STEP_UA
                  * ({8'h00, $past(operation_mode[PUMP_CUR_MSB:PUMP_CUR_LSB])} + 11'h001))
  ) else $error("pump current does not follow its code");
  chk_fixed_settings: assert property (
    pump_delay_select == PUMP_DLY_FIXED && detector_polarity == POLARITY_FIXED
  ) else $error("fixed delay or polarity not applied");
  chk_pump_disable: assert property (
    ce ##1 ce |-> pump_output_disable == $past(operation_mode[PUMP_OFF_BIT])
  ) else $error("pump disable does not follow its bit");

  // diagnostic routing to the lock detect pin, unused codes drive low
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      diag_out <= 1'b0;
    end else if (ce) begin
      case (operation_mode[DIAG_MSB:DIAG_LSB])
        DIAG_LOCK:      diag_out <= lock_detect_in;
        DIAG_REF_DIV:   diag_out <= ref_div_in;
        DIAG_N_DIV:     diag_out <= n_div_in;
        DIAG_LOOP_TEST: diag_out <= loop_test_in;
        default:        diag_out <= 1'b0;
      endcase
    end
  end

  chk_diag_route: assert property (
    ce && operation_mode[DIAG_MSB:DIAG_LSB] == DIAG_N_DIV |=> diag_out == $past(n_div_in)
  ) else $error("diagnostic output not routed");

  // digital loop control ports and enable edge
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      loop_ctrl    <= 18'h00000;
      loop_enable  <= 1'b0;
      loop_en_prev <= 1'b0;
    end else if (ce) begin
      loop_ctrl    <= auto_calibration_control[LOOP_CTRL_MSB:LOOP_CTRL_LSB];
      loop_enable  <= auto_calibration_control[LOOP_EN_BIT];
      loop_en_prev <= auto_calibration_control[LOOP_EN_BIT];
    end
  end

  assign loop_en_rise = auto_calibration_control[LOOP_EN_BIT] & ~loop_en_prev;
  assign freq_ctrl_one = frequency_control_one;
  assign freq_ctrl_two = frequency_control_two;

  // start request: set at power on, set by enable rise, cleared when taken
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      start_req <= 1'b1;
    end else if (ce) begin
      if (loop_en_rise) begin
        start_req <= 1'b1;
      end else begin
        start_req <= 1'b0; // taken by the sequencer in any state
      end
    end
  end

  assign step_end = (tune_cnt == TUNE_STEP_LAST);

  // successive approximation search over the coarse code
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      tune_state  <= TUNE_IDLE;
      tune_idx    <= TUNE_TOP_IDX;
      tune_cnt    <= 10'h000;
      coarse_code <= TUNE_CODE_RST;
    end else if (ce) begin
      case (tune_state)
        TUNE_IDLE, TUNE_DONE: begin
          if (start_req) begin
            tune_state  <= TUNE_SETTLE;
            tune_idx    <= TUNE_TOP_IDX;
            tune_cnt    <= 10'h000;
            coarse_code <= TUNE_CODE_MID;
          end
        end
        TUNE_SETTLE: begin
          if (start_req) begin
            tune_idx    <= TUNE_TOP_IDX;
            tune_cnt    <= 10'h000;
            coarse_code <= TUNE_CODE_MID;
          end else if (!step_end) begin
            tune_cnt <= tune_cnt + 10'h001;
          end else begin
            tune_cnt <= 10'h000;
            if (tune_idx == 3'h0) begin
              coarse_code[0] <= ~vco_freq_high;
              tune_state     <= TUNE_DONE;
            end else begin
              coarse_code[tune_idx]        <= ~vco_freq_high;
              coarse_code[tune_idx - 3'h1] <= 1'b1;
              tune_idx                     <= tune_idx - 3'h1;
            end
          end
        end
        default: tune_state <= TUNE_IDLE;
      endcase
    end
  end

  // tuning status flags
  always_ff @(posedge clk or negedge nrst_q) begin
    if (!nrst_q) begin
      tune_busy      <= 1'b0;
      analog_tune_en <= 1'b0;
    end else if (ce) begin
      tune_busy      <= (tune_state == TUNE_SETTLE);
      analog_tune_en <= (tune_state == TUNE_DONE);
    end
  end

  chk_search_finish: assert property (
    tune_state == TUNE_SETTLE && step_end && tune_idx == 3'h0 && !start_req
      |=> tune_state == TUNE_DONE ##1 analog_tune_en
  ) else $error("search did not finish after the last step");
  chk_analog_after: assert property (
    analog_tune_en |-> $past(tune_state) == TUNE_DONE
  ) else $error("analog tuning switched in during search");
  chk_code_hold: assert property (
    tune_state == TUNE_DONE && !start_req |=> $stable(coarse_code)
  ) else $error("coarse code moved after search");
  chk_tune_start: assert property (
    loop_en_rise && tune_state != TUNE_SETTLE
      |-> ##[1:2] tune_state == TUNE_SETTLE && coarse_code == TUNE_CODE_MID
  ) else $error("enable rise did not start a search");

endmodule // sscr_top
`default_nettype wire

/* core/sscr_pkg.sv */
// shared constants of the synthesizer serial control block
package sscr_pkg;
  // serial word and holding register shape
  localparam int          WORD_BITS      = 26;
  localparam int          HOLD_BITS      = 24;
  localparam logic [23:0] HOLD_RESET     = 24'h000000;
  localparam logic [25:0] LOAD_RESET     = 26'h0000000;
  // word address codes
  localparam logic [1:0]  ADDR_OPMODE    = 2'h0;
  localparam logic [1:0]  ADDR_AUTOCAL   = 2'h1;
  localparam logic [1:0]  ADDR_FREQ_ONE  = 2'h2;
  localparam logic [1:0]  ADDR_FREQ_TWO  = 2'h3;
  // operation mode fields
  localparam int          PUMP_CUR_LSB   = 2;
  localparam int          PUMP_CUR_MSB   = 4;
  localparam int          PUMP_DLY_LSB   = 5;
  localparam int          PUMP_DLY_MSB   = 6;
  localparam int          POLARITY_BIT   = 7;
  localparam int          PUMP_OFF_BIT   = 8;
  localparam int          MOD_SUPPLY_BIT = 10;
  localparam int          DIV_SUPPLY_BIT = 11;
  localparam int          PLL_SUPPLY_BIT = 12;
  localparam int          REF_BW_LSB     = 13;
  localparam int          REF_BW_MSB     = 14;
  localparam int          DIAG_LSB       = 15;
  localparam int          DIAG_MSB       = 17;
  localparam int          PRE_BIAS_LSB   = 21;
  localparam int          PRE_BIAS_MSB   = 22;
  localparam int          PRE_RATIO_BIT  = 23;
  // auto calibration fields
  localparam int          LOOP_CTRL_LSB  = 2;
  localparam int          LOOP_CTRL_MSB  = 19;
  localparam int          LOOP_EN_BIT    = 20;
  // fixed applied settings
  localparam logic [1:0]  PUMP_DLY_FIXED = 2'h0;
  localparam logic        POLARITY_FIXED = 1'h0;
  // analog setting scales
  localparam logic [10:0] PUMP_STEP_UA   = 11'h0C8;
  localparam logic [5:0]  REF_BW_BASE    = 6'h14;
  localparam logic [5:0]  REF_BW_STEP    = 6'h0A;
  localparam logic [4:0]  PRE_BIAS_BASE  = 5'h14;
  localparam logic [4:0]  PRE_BIAS_STEP  = 5'h02;
  // diagnostic routing codes
  localparam logic [2:0]  DIAG_LOCK      = 3'h0;
  localparam logic [2:0]  DIAG_REF_DIV   = 3'h1;
  localparam logic [2:0]  DIAG_N_DIV     = 3'h2;
  localparam logic [2:0]  DIAG_LOOP_TEST = 3'h7;
  // coarse tuning search
  localparam int          TUNE_BITS      = 7;
  localparam logic [2:0]  TUNE_TOP_IDX   = 3'h6;
  localparam logic [6:0]  TUNE_CODE_MID  = 7'h40;
  localparam logic [6:0]  TUNE_CODE_RST  = 7'h00;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          TUNE_STEP_NS   = 1000;
  localparam int          TUNE_STEP_CYC  = (TUNE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  TUNE_STEP_LAST = 10'(TUNE_STEP_CYC - 1);
  // search sequencer states
  typedef enum logic [1:0] {
    TUNE_IDLE,
    TUNE_SETTLE,
    TUNE_DONE
  } sscr_tune_t;
endpackage

/* sim/sscr_host.sv */
// host model that drives the three wire programming link
`timescale 1ns/1ns
`default_nettype none
module sscr_host (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  // link idles with the clock still and the strobe high
  initial begin
    ser_clk      = 1'b0;
    ser_data     = 1'b0;
    latch_strobe = 1'b1;
  end

  // shift one word msb first, then a short low pulse latches it
  task automatic send_word(input logic [25:0] word);
    latch_strobe = 1'b0;
    #16;
    for (int i = 25; i >= 0; i--) begin
      ser_data = word[i];
      #6;
      ser_clk  = 1'b0;
      #16;
      ser_clk  = 1'b1;
      #10;
    end
    // data hold has run out, so the line stops showing the last bit
    ser_data     = ~word[0];
    #6;
    ser_clk      = 1'b0;
    #20;
    latch_strobe = 1'b1;
    #32;
    latch_strobe = 1'b0;
    #32;
    latch_strobe = 1'b1;
    #32;
  endtask
endmodule  // sscr_host
`default_nettype wire

/* sim/sscr_top_tb.sv */
// self-checking bench of the serial control block
`timescale 1ns/1ns
`default_nettype none
module sscr_top_tb;
  import sscr_pkg::*;
  localparam int WATCH_CYC = 60000;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        vco_freq_high = 1'b0;
  logic        lock_detect_in = 1'b0;
  logic        ref_div_in = 1'b0;
  logic        n_div_in = 1'b0;
  logic        loop_test_in = 1'b0;
  logic        ser_clk, ser_data, latch_strobe;
  logic [2:0]  pump_current_select;
  logic [10:0] pump_current_ua;
  logic [1:0]  pump_delay_select, reference_buffer_bandwidth;
  logic        detector_polarity, pump_output_disable, modulator_supply_ctrl;
  logic        divider_supply_ctrl, pll_supply_ctrl, diag_out, prescaler_ratio_sel;
  logic [5:0]  ref_bw_mhz;
  logic [4:0]  prescaler_bias_ua;
  logic [17:0] loop_ctrl;
  logic        loop_enable, tune_busy, analog_tune_en;
  logic [23:0] freq_ctrl_one, freq_ctrl_two, f;
  logic [6:0]  coarse_code, target = 7'h00;
  int          err_count = 0;
  int          check_count = 0;

  sscr_host i_host (.ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));

  sscr_top i_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_strobe(latch_strobe), .vco_freq_high(vco_freq_high),
    .lock_detect_in(lock_detect_in), .ref_div_in(ref_div_in), .n_div_in(n_div_in),
    .loop_test_in(loop_test_in), .pump_current_select(pump_current_select),
    .pump_current_ua(pump_current_ua), .pump_delay_select(pump_delay_select),
    .detector_polarity(detector_polarity), .pump_output_disable(pump_output_disable),
    .modulator_supply_ctrl(modulator_supply_ctrl), .divider_supply_ctrl(divider_supply_ctrl),
    .pll_supply_ctrl(pll_supply_ctrl), .reference_buffer_bandwidth(reference_buffer_bandwidth),
    .ref_bw_mhz(ref_bw_mhz), .diag_out(diag_out), .prescaler_bias_ua(prescaler_bias_ua),
    .prescaler_ratio_sel(prescaler_ratio_sel), .loop_ctrl(loop_ctrl), .loop_enable(loop_enable),
    .freq_ctrl_one(freq_ctrl_one), .freq_ctrl_two(freq_ctrl_two), .coarse_code(coarse_code),
    .tune_busy(tune_busy), .analog_tune_en(analog_tune_en));

  // 250 MHz system clock
  initial begin
    forever #2 clk = ~clk;
  end

  // oscillator comparator: above target whenever the trial code exceeds it
  always @(posedge clk) begin
    vco_freq_high <= #1 (coarse_code > target);
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // diagnostic sources: only the routed one high, all high for unused codes
  function automatic logic [3:0] diag_src(input logic [2:0] sel);
    case (sel)
      DIAG_LOCK:      return 4'h8;
      DIAG_REF_DIV:   return 4'h4;
      DIAG_N_DIV:     return 4'h2;
      DIAG_LOOP_TEST: return 4'h1;
      default:        return 4'hF;
    endcase
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // count the search length and judge its outcome
  task automatic wait_done();
    int n;
    n = 0;
    while (tune_busy === 1'b1 && n < 2200) begin
      settle(1);
      n++;
    end
    check("search cycles", 1, n >= 7 * TUNE_STEP_CYC - 20 && n <= 7 * TUNE_STEP_CYC + 4);
    check("analog_tune_en", 1, analog_tune_en);
    check("coarse_code", target, coarse_code);
  endtask

  // reset, default outputs and the automatic power-on search
  task automatic reset_run();
    int n;
    nrst = 1'b0;
    target = 7'($urandom);
    settle(10);
    nrst = 1'b1;
    check("pump_current_ua", 200, pump_current_ua);
    check("ref_bw_mhz", 20, ref_bw_mhz);
    check("prescaler_bias_ua", 20, prescaler_bias_ua);
    n = 0;
    while (tune_busy !== 1'b1 && n < 20) begin
      settle(1);
      n++;
    end
    check("power-on busy", 1, tune_busy);
    wait_done();
  endtask

  task automatic opmode_case(input logic [23:0] v);
    {lock_detect_in, ref_div_in, n_div_in, loop_test_in} = diag_src(v[17:15]);
    i_host.send_word({2'h0, v[23:2], ADDR_OPMODE});
    settle(4);
    check("pump_current_select", v[4:2], pump_current_select);
    check("pump_current_ua", 200 * (v[4:2] + 1), pump_current_ua);
    check("pump_delay_select", 0, pump_delay_select);
    check("detector_polarity", 0, detector_polarity);
    check("pump_output_disable", v[8], pump_output_disable);
    check("supply bits", v[12:10], {pll_supply_ctrl, divider_supply_ctrl, modulator_supply_ctrl});
    check("ref_bw_mhz", 20 + 10 * v[14:13], ref_bw_mhz);
    check("reference_buffer_bandwidth", v[14:13], reference_buffer_bandwidth);
    check("diag_out", diag_src(v[17:15]) != 4'hF, diag_out);
    check("prescaler_bias_ua", 20 + 2 * v[22:21], prescaler_bias_ua);
    check("prescaler_ratio_sel", v[23], prescaler_ratio_sel);
  endtask

  task automatic autocal(input logic [17:0] ctrl, input logic en);
    i_host.send_word({5'h00, en, ctrl, ADDR_AUTOCAL});
    settle(4);
    check("loop_ctrl", ctrl, loop_ctrl);
    check("loop_enable", en, loop_enable);
  endtask

  // watchdog against a hung run
  initial begin
    repeat (WATCH_CYC) @(posedge clk);
    err_count++;
    $display("[ERR] watchdog expected completion seen timeout");
    conclude();
  end

  initial begin
    void'($urandom(32'hED5B));
    reset_run();
    // every diagnostic code, all-ones and the recommended settings
    for (int i = 0; i < 10; i++) begin
      f = 24'($urandom);
      if (i < 8) f[17:15] = 3'(i);
      if (i == 8) f = 24'hFFFFFF;
      if (i == 9) f = 24'h607000;
      opmode_case(f);
    end
    // frequency words leave the operation mode settings alone
    f = 24'($urandom);
    i_host.send_word({2'h0, f[23:2], ADDR_FREQ_ONE});
    i_host.send_word({2'h0, ~f[23:2], ADDR_FREQ_TWO});
    settle(4);
    check("freq_ctrl_one", {f[23:2], ADDR_FREQ_ONE}, freq_ctrl_one);
    check("freq_ctrl_two", {~f[23:2], ADDR_FREQ_TWO}, freq_ctrl_two);
    check("pump_current_ua kept", 200 * (3'h0 + 1), pump_current_ua);
    // enable low then high starts a new search
    autocal(18'($urandom), 1'b0);
    check("no start", 0, tune_busy);
    target = ~coarse_code;
    autocal(18'($urandom), 1'b1);
    check("enable busy", 1, tune_busy);
    check("analog off", 0, analog_tune_en);
    // a fresh rise during the search restarts it from the middle code
    autocal(18'($urandom), 1'b0);
    autocal(18'($urandom), 1'b1);
    check("restart code", TUNE_CODE_MID, coarse_code);
    check("restart busy", 1, tune_busy);
    wait_done();
    // enable written high again without a rise keeps the code
    f[6:0] = coarse_code;
    // clock enable low freezes link and tuning, so this word is lost
    ce = 1'b0;
    i_host.send_word({5'h00, 1'b0, 18'h00000, ADDR_AUTOCAL});
    ce = 1'b1;
    settle(4);
    check("frozen loop_enable", 1, loop_enable);
    check("frozen code", f[6:0], coarse_code);
    target = 7'($urandom);
    autocal(18'h3FFFF, 1'b1);
    settle(20);
    check("held busy", 0, tune_busy);
    check("held code", f[6:0], coarse_code);
    target = f[6:0] ^ 7'h2A;
    reset_run();
    check("freq cleared", 0, freq_ctrl_one);
    conclude();
  end
endmodule  // sscr_top_tb
`default_nettype wire
